// file: verilog/rhd_root_hub_regs.sv
`timescale 1ns/1ps
// Contract
// - Overcurrent report mode 0 reports all ports together, 1 per port.
// - The compound type flag always reads 0.
// - No power switching 0 means switched ports, 1 means always powered.
// - Power switch mode acts only while no power switching is clear.
// - Mode 0 powers ports together, mode 1 powers them individually.
// - Downstream port count sits in bits 7 to 0 and lies in 1 to 15.
// - The port power mask in bits 31 to 16 is ignored in mode 0.
// - Mask bit 0 is reserved; bits 1 and 2 cover ports 1 and 2.
// - Removable flags in bits 15 to 0, bit 0 reserved, set = fixed.
// - Report mode counts only with protection present; resets as mode.
// - Global set powers all ports, or only unmasked ones in mode 1.
module rhd_root_hub_regs
  import rhd_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic glob_pwr_set_in,
  input wire logic glob_pwr_clr_in,
  input wire logic [15:0] port_pwr_set_in,
  input wire logic [15:0] port_pwr_clr_in,
  output logic [31:0] reg_rdata_out,
  output logic oc_per_port_out,
  output logic [15:0] port_power_out,
  output logic [15:0] removable_out
);

  typedef struct packed {
    logic no_overcurrent_protect;
    logic overcurrent_report_mode;
    logic no_power_switching;
    logic power_switch_mode;
    logic [15:0] mask;
    logic [15:0] device_removable_flags;
    logic [31:0] rdata;
    logic oc_per_port;
  } rhd_regs_state_t;

  rhd_regs_state_t st_reg;
  rhd_regs_state_t st_next;
  logic [31:0] caps_word;
  logic [31:0] masks_word;
  logic wr_caps;
  logic wr_masks;

  rhd_pwr_if pwr ();

  // ----------------------------------------------------------------
  // Read images
  // ----------------------------------------------------------------
  always_comb begin
    caps_word = 32'h0000_0000;
    caps_word[RHD_NO_OC_PROT_BIT] = st_reg.no_overcurrent_protect;
    caps_word[RHD_OC_MODE_BIT] = st_reg.overcurrent_report_mode;
    caps_word[RHD_COMPOUND_BIT] = RHD_COMPOUND_VAL;
    caps_word[RHD_NO_SWITCH_BIT] = st_reg.no_power_switching;
    caps_word[RHD_SWITCH_MODE_BIT] = st_reg.power_switch_mode;
    caps_word[RHD_PORT_COUNT_LSB +: RHD_PORT_COUNT_W] = RHD_PORT_COUNT;
    masks_word = {st_reg.mask, st_reg.device_removable_flags};
  end

  assign wr_caps = reg_wr_in && (reg_addr_in == RHD_CAPS_OFFSET);
  assign wr_masks = reg_wr_in && (reg_addr_in == RHD_MASKS_OFFSET);

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (wr_caps) begin
      st_next.no_overcurrent_protect = reg_wdata_in[RHD_NO_OC_PROT_BIT];
      st_next.overcurrent_report_mode = reg_wdata_in[RHD_OC_MODE_BIT];
      st_next.no_power_switching = reg_wdata_in[RHD_NO_SWITCH_BIT];
      st_next.power_switch_mode = reg_wdata_in[RHD_SWITCH_MODE_BIT];
    end
    if (wr_masks) begin
      st_next.mask = reg_wdata_in[RHD_PWR_MASK_LSB +: RHD_PORTS_W]
        & RHD_PORT_KEEP;
      st_next.device_removable_flags =
        reg_wdata_in[RHD_REMOVABLE_LSB +: RHD_PORTS_W] & RHD_PORT_KEEP;
    end
    // Unmapped reads return zero so software never sees stale data
    st_next.rdata = 32'h0000_0000;
    if (reg_rd_in && reg_addr_in == RHD_CAPS_OFFSET) begin
      st_next.rdata = caps_word;
    end else if (reg_rd_in && reg_addr_in == RHD_MASKS_OFFSET) begin
      st_next.rdata = masks_word;
    end
    // per-port reporting only with protection present
    st_next.oc_per_port = !st_reg.no_overcurrent_protect
      && st_reg.overcurrent_report_mode;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg.no_overcurrent_protect <= RHD_NO_OC_PROT_RST;
      // report mode starts equal to switch mode
      st_reg.overcurrent_report_mode <= RHD_SWITCH_MODE_RST;
      st_reg.no_power_switching <= RHD_NO_SWITCH_RST;
      st_reg.power_switch_mode <= RHD_SWITCH_MODE_RST;
      st_reg.mask <= RHD_PWR_MASK_RST;
      st_reg.device_removable_flags <= RHD_REMOVABLE_RST;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.oc_per_port <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Port power switching
  // ----------------------------------------------------------------
  assign pwr.no_power_switching = st_reg.no_power_switching;
  // switch mode meaningful only when switching exists
  assign pwr.power_switch_mode = st_reg.power_switch_mode
    && !st_reg.no_power_switching;
  assign pwr.mask = pwr.power_switch_mode ? st_reg.mask : 16'h0000;
  assign pwr.valid = rhd_valid_ports(RHD_PORT_COUNT);
  assign pwr.glob_set = glob_pwr_set_in;
  assign pwr.glob_clr = glob_pwr_clr_in;
  assign pwr.port_set = port_pwr_set_in;
  assign pwr.port_clr = port_pwr_clr_in;

  rhd_port_switch u_switch (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pwr(pwr)
  );

  assign reg_rdata_out = st_reg.rdata;
  assign oc_per_port_out = st_reg.oc_per_port;
  assign port_power_out = pwr.power;
  assign removable_out = st_reg.device_removable_flags;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_wr_caps;
    reg_wr_in && reg_addr_in == RHD_CAPS_OFFSET;
  endsequence

  sequence s_wr_masks;
    reg_wr_in && reg_addr_in == RHD_MASKS_OFFSET;
  endsequence

  sequence s_rd_caps;
    reg_rd_in && reg_addr_in == RHD_CAPS_OFFSET && !reg_wr_in;
  endsequence

  sequence s_rd_masks;
    reg_rd_in && reg_addr_in == RHD_MASKS_OFFSET && !reg_wr_in;
  endsequence

  AST_PER_PORT_REPORT: assert property (
    s_wr_caps ##1 !reg_wr_in |=> oc_per_port_out ==
      (!$past(reg_wdata_in[RHD_NO_OC_PROT_BIT], 2)
       && $past(reg_wdata_in[RHD_OC_MODE_BIT], 2)))
    else $error("report mode output does not follow written bits");

  AST_COMPOUND_READS_ZERO: assert property (
    s_rd_caps |=> !reg_rdata_out[RHD_COMPOUND_BIT])
    else $error("compound type flag read as one");

  AST_NO_SWITCH_READBACK: assert property (
    s_wr_caps ##1 s_rd_caps |=> reg_rdata_out[RHD_NO_SWITCH_BIT] ==
      $past(reg_wdata_in[RHD_NO_SWITCH_BIT], 2))
    else $error("no power switching bit lost on write");

  AST_PORT_COUNT: assert property (
    s_rd_caps |=> reg_rdata_out[7:0] == RHD_PORT_COUNT
      && reg_rdata_out[7:0] >= RHD_PORT_COUNT_MIN
      && reg_rdata_out[7:0] <= RHD_PORT_COUNT_MAX)
    else $error("port count out of range");

  AST_MASK_BIT0: assert property (
    s_rd_masks |=> !reg_rdata_out[RHD_PWR_MASK_LSB])
    else $error("reserved mask bit read as one");

  AST_REMOVABLE_READBACK: assert property (
    s_wr_masks ##1 s_rd_masks |=> reg_rdata_out[15:0] ==
      ($past(reg_wdata_in[15:0], 2) & RHD_PORT_KEEP))
    else $error("removable flags read back wrong");

  AST_REPORT_MODE_RESET: assert property (
    $past(reset_in) |-> st_reg.overcurrent_report_mode
      == st_reg.power_switch_mode)
    else $error("report mode differs from switch mode after reset");

  AST_NO_PROTECT: assert property (
    st_reg.no_overcurrent_protect [*2] |-> !oc_per_port_out)
    else $error("per-port report with protection absent");

  AST_MODE_GATED: assert property (
    st_reg.no_power_switching |-> !pwr.power_switch_mode
      && pwr.mask == 16'h0000)
    else $error("switch mode active without switching");

  AST_MODE0_MASK_IGNORED: assert property (
    !st_reg.no_power_switching && !st_reg.power_switch_mode
      && st_reg.mask[1] && glob_pwr_clr_in && !glob_pwr_set_in
      |=> !port_power_out[1])
    else $error("stored mask honoured in global switching mode");

endmodule

// file: verilog/rhd_pkg.sv
package rhd_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] RHD_CAPS_OFFSET = 8'h48;
  localparam logic [7:0] RHD_MASKS_OFFSET = 8'h4c;

  // ----------------------------------------------------------------
  // Capabilities register fields
  // ----------------------------------------------------------------
  localparam int RHD_NO_OC_PROT_BIT = 12;
  localparam int RHD_OC_MODE_BIT = 11;
  localparam int RHD_COMPOUND_BIT = 10;
  localparam int RHD_NO_SWITCH_BIT = 9;
  localparam int RHD_SWITCH_MODE_BIT = 8;
  localparam int RHD_PORT_COUNT_LSB = 0;
  localparam int RHD_PORT_COUNT_W = 8;

  // ----------------------------------------------------------------
  // Port masks register fields
  // ----------------------------------------------------------------
  localparam int RHD_PWR_MASK_LSB = 16;
  localparam int RHD_REMOVABLE_LSB = 0;
  localparam int RHD_PORTS_W = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RHD_NO_OC_PROT_RST = 1'b0;
  localparam logic RHD_SWITCH_MODE_RST = 1'b1;
  localparam logic RHD_NO_SWITCH_RST = 1'b0;
  localparam logic RHD_COMPOUND_VAL = 1'b0;
  localparam logic [7:0] RHD_PORT_COUNT = 8'h01;
  localparam logic [7:0] RHD_PORT_COUNT_MIN = 8'h01;
  localparam logic [7:0] RHD_PORT_COUNT_MAX = 8'h0f;
  localparam logic [15:0] RHD_PWR_MASK_RST = 16'h0002;
  localparam logic [15:0] RHD_REMOVABLE_RST = 16'h0000;
  // Bit 0 of both per-port fields is reserved and held at zero
  localparam logic [15:0] RHD_PORT_KEEP = 16'hfffe;

  function automatic logic [15:0] rhd_valid_ports(input logic [7:0] cnt);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 1; i < 16; i++) begin
      v[i] = (8'(i) <= cnt);
    end
    return v;
  endfunction

endpackage

// file: verilog/rhd_pwr_if.sv
`timescale 1ns/1ps
interface rhd_pwr_if;
  logic no_power_switching;
  logic power_switch_mode;
  logic [15:0] mask;
  logic [15:0] valid;
  logic glob_set;
  logic glob_clr;
  logic [15:0] port_set;
  logic [15:0] port_clr;
  logic [15:0] power;

  modport ctrl (
    output no_power_switching, power_switch_mode, mask, valid,
    output glob_set, glob_clr, port_set, port_clr,
    input power
  );
  modport sw (
    input no_power_switching, power_switch_mode, mask, valid,
    input glob_set, glob_clr, port_set, port_clr,
    output power
  );
endinterface

// file: verilog/rhd_port_switch.sv
`timescale 1ns/1ps
module rhd_port_switch
  import rhd_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  rhd_pwr_if.sw pwr
);

  typedef struct packed {
    logic [15:0] power;
  } rhd_sw_state_t;

  rhd_sw_state_t st_reg;
  rhd_sw_state_t st_next;

  // ----------------------------------------------------------------
  // Port power switching
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    for (int i = 1; i < 16; i++) begin
      if (pwr.no_power_switching) begin
        st_next.power[i] = 1'b1;
      end else if (!pwr.power_switch_mode || !pwr.mask[i]) begin
        // ganged control; mask ignored in global mode
        // global set reaches every port in mode 0, unmasked ports only in mode 1
        if (pwr.glob_set) begin
          st_next.power[i] = 1'b1;
        end else if (pwr.glob_clr) begin
          st_next.power[i] = 1'b0;
        end
      end else begin
        // masked port follows per-port commands only
        if (pwr.port_set[i]) begin
          st_next.power[i] = 1'b1;
        end else if (pwr.port_clr[i]) begin
          st_next.power[i] = 1'b0;
        end
      end
    end
    // Lanes beyond the port count never carry power
    st_next.power = st_next.power & pwr.valid;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pwr.power = st_reg.power;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  AST_UNSWITCHED_ALL_ON: assert property (
    pwr.no_power_switching |=> pwr.power == $past(pwr.valid))
    else $error("ports not all powered with switching absent");

  AST_GLOBAL_SET: assert property (
    !pwr.no_power_switching && !pwr.power_switch_mode && pwr.glob_set
      |=> pwr.power == $past(pwr.valid))
    else $error("global set did not power every port");

  AST_MASKED_IGNORES_GLOBAL: assert property (
    !pwr.no_power_switching && pwr.power_switch_mode && pwr.mask[1]
      && !pwr.port_set[1] && !pwr.port_clr[1]
      |=> pwr.power[1] == $past(pwr.power[1]))
    else $error("masked port moved without a per-port command");

  AST_UNMASKED_GLOBAL_SET: assert property (
    !pwr.no_power_switching && pwr.power_switch_mode && !pwr.mask[1]
      && pwr.glob_set && pwr.valid[1] |=> pwr.power[1])
    else $error("unmasked port missed the global set");

  // Mask arrives zeroed in global mode, so a global clear without a global set must act
  AST_GLOBAL_IGNORES_MASK: assert property (
    !pwr.no_power_switching && !pwr.power_switch_mode && pwr.glob_clr
      && !pwr.glob_set |=> !pwr.power[1])
    else $error("mask honoured in global switching mode");

endmodule

// file: verif/tb_rhd_root_hub_regs.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  error_cnt++; $display("wrong value at %0t: got %h expected %h", \
  $time, got, exp); end end
module tb_rhd_root_hub_regs;
  import rhd_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic glob_pwr_set_in = 1'b0;
  logic glob_pwr_clr_in = 1'b0;
  logic [15:0] port_pwr_set_in = 16'h0;
  logic [15:0] port_pwr_clr_in = 16'h0;
  logic [31:0] reg_rdata_out;
  logic oc_per_port_out;
  logic [15:0] port_power_out;
  logic [15:0] removable_out;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hfb4947b7;
  logic [31:0] q, c, m, r;
  logic pw;

  rhd_root_hub_regs u_dut (
    .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .glob_pwr_set_in(glob_pwr_set_in),
    .glob_pwr_clr_in(glob_pwr_clr_in), .port_pwr_set_in(port_pwr_set_in),
    .port_pwr_clr_in(port_pwr_clr_in), .reg_rdata_out(reg_rdata_out),
    .oc_per_port_out(oc_per_port_out), .port_power_out(port_power_out),
    .removable_out(removable_out)
  );

  always #25 clk_in = ~clk_in;

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Only no_overcurrent_protect, overcurrent_report_mode, nps and psm are writable; count stays at one port
  function automatic logic [31:0] caps_exp(input logic [31:0] d);
    return (d & 32'h0000_1b00) | 32'h0000_0001;
  endfunction

  // Power model of port 1, the only port within the count
  function automatic logic pwr_next(input logic p, input logic mode,
    input logic m1, input logic gs, input logic gc, input logic ps,
    input logic pc);
    logic s, k;
    s = (mode && m1) ? ps : gs;
    k = (mode && m1) ? pc : gc;
    return s ? 1'b1 : (k ? 1'b0 : p);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
  endtask

  task automatic cmd(input logic gs, input logic gc,
    input logic [15:0] ps, input logic [15:0] pc);
    glob_pwr_set_in = gs;
    glob_pwr_clr_in = gc;
    port_pwr_set_in = ps;
    port_pwr_clr_in = pc;
    @(negedge clk_in);
    glob_pwr_set_in = 1'b0;
    glob_pwr_clr_in = 1'b0;
    port_pwr_set_in = 16'h0;
    port_pwr_clr_in = 16'h0;
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    reset_in = 1'b0;
    rd(RHD_CAPS_OFFSET, q);
    `CHK(q, 32'h0000_0901)
    `CHK(oc_per_port_out, 1'b1)
    `CHK(port_power_out, 16'h0000)
    @(negedge clk_in);
    `CHK(reg_rdata_out, 32'h0)
    rd(RHD_MASKS_OFFSET, q);
    `CHK(q, 32'h0002_0000)
    `CHK(removable_out, 16'h0000)
    // Unmapped and near-miss addresses are ignored
    wr(8'h50, rnd());
    // Idle edge between like transfers so a strobe never toggles twice
    @(negedge clk_in);
    wr(8'h49, rnd());
    rd(8'h50, q);
    `CHK(q, 32'h0)
    @(negedge clk_in);
    rd(RHD_CAPS_OFFSET, q);
    `CHK(q, 32'h0000_0901)
    // Always-powered ports ignore clear commands
    wr(RHD_CAPS_OFFSET, 32'h0000_0200);
    repeat (2) @(negedge clk_in);
    `CHK(port_power_out, 16'h0002)
    cmd(1'b0, 1'b1, 16'h0, 16'hffff);
    @(negedge clk_in);
    `CHK(port_power_out, 16'h0002)
    wr(RHD_CAPS_OFFSET, 32'h0000_0100);
    cmd(1'b0, 1'b1, 16'h0, 16'hffff);
    `CHK(port_power_out, 16'h0000)
    @(negedge clk_in);
    // Same-cycle set and clear: set wins for masked port 1 in mode 1
    cmd(1'b1, 1'b1, 16'hffff, 16'hffff);
    `CHK(port_power_out, 16'h0002)
    pw = 1'b1;
    for (int i = 0; i < 60; i++) begin
      c = rnd() & 32'hff00_1f00;
      c[9] = 1'b0;
      wr(RHD_CAPS_OFFSET, c);
      rd(RHD_CAPS_OFFSET, q);
      `CHK(q, caps_exp(c))
      `CHK(oc_per_port_out, !c[12] && c[11])
      m = rnd() & 32'hfffe_fffe;
      wr(RHD_MASKS_OFFSET, m);
      `CHK(removable_out, m[15:0] & 16'hfffe)
      rd(RHD_MASKS_OFFSET, q);
      `CHK(q, m & 32'hfffe_fffe)
      r = rnd();
      pw = pwr_next(pw, c[8], m[17], r[0], r[1], r[17], r[1]);
      cmd(r[0], r[1], r[31:16], r[15:0] ^ 16'h5555);
      `CHK(port_power_out, {14'h0, pw, 1'b0})
      @(negedge clk_in);
      r = rnd();
      pw = pwr_next(pw, c[8], m[17], r[4], 1'b0, r[5], 1'b0);
      cmd(r[4], 1'b0, {r[15:2], r[5], 1'b0}, 16'h0);
      `CHK(port_power_out, {14'h0, pw, 1'b0})
    end
    finish_test();
  end
endmodule
